// >>> scmux_pkg.sv
/*
  Package for the serial clock mux and frame-align logic.
  Assumes an APB slave at 10 MHz with a 32-bit data bus.
*/
// Overview of operation
// - Oscillator bit clear disables oscillator; clock and align pins act normally.
// - Oscillator bit set routes the recv/xmit clock-pin selection to oscillator output.
// - Oscillator on in sync modes: no sync pulse, no external sync mode.
// - Oscillator on in async mode forces sync/hunt status to zero.
// - Receive clock chosen from four sources by bits 6 and 5.
// - Transmit clock chosen from four sources by bits 4 and 3.
// - Xmit/recv pin drives only when not a clock source and bit 2 set.
// - Driven pin outputs one of four signals chosen by bits 1 and 0.
// - Oscillator selected on pin while oscillator is off drives pin high.
// - Receiver samples on rising edge of the selected receive clock.
// - External sync mode: sync/hunt status mirrors align pin; software sets hunt.
// - Align pin low two clocks after sync; assembly starts next rising clock.
// - Both align pin transitions raise a status event when enable set.
// - Align falling edge ends hunt; receive continues until enter-hunt command.
// - SDLC external sync: align pin acts like a received flag.
// - Sync external sync: transmitter monosync, align pin starts reception.
package scmux_pkg;

  localparam logic [11:0] SCMUX_ADDR_CMC    = 12'h000;
  localparam logic [11:0] SCMUX_ADDR_MODE   = 12'h004;
  localparam logic [11:0] SCMUX_ADDR_CMD    = 12'h008;
  localparam logic [11:0] SCMUX_ADDR_STATUS = 12'h00C;

  localparam int SCMUX_OSC_BIT     = 7;
  localparam int SCMUX_RXSRC_LSB   = 5;
  localparam int SCMUX_TXSRC_LSB   = 3;
  localparam int SCMUX_PINOUT_BIT  = 2;
  localparam int SCMUX_PINSEL_LSB  = 0;
  localparam int SCMUX_MODE_LSB    = 0;
  localparam int SCMUX_IE_BIT      = 2;
  localparam int SCMUX_CMD_HUNT    = 0;
  localparam int SCMUX_CMD_EVCLR   = 1;

  localparam logic [7:0] SCMUX_CMC_RST  = 8'h00;
  localparam logic [2:0] SCMUX_MODE_RST = 3'h0;
  localparam logic [6:0] SCMUX_PIN_RST  = 7'h10;

  localparam int SCMUX_OSC_SETTLE_MS = 20;
  localparam int SCMUX_CLK_HZ        = 10_000_000;
  localparam int SCMUX_OSC_SETTLE_CYC = SCMUX_OSC_SETTLE_MS * (SCMUX_CLK_HZ / 1000);

  typedef enum logic [1:0] {
    SCMUX_SRC_RECV_XMIT_CLOCK_PIN = 2'b00,
    SCMUX_SRC_XMIT_RECV_CLOCK_PIN = 2'b01,
    SCMUX_SRC_BAUD = 2'b10,
    SCMUX_SRC_LOOP = 2'b11
  } scmux_src_t;

  typedef enum logic [1:0] {
    SCMUX_PIN_OSC  = 2'b00,
    SCMUX_PIN_TXC  = 2'b01,
    SCMUX_PIN_BAUD = 2'b10,
    SCMUX_PIN_LOOP = 2'b11
  } scmux_pinsel_t;

  typedef enum logic [1:0] {
    SCMUX_MODE_ASYNC = 2'b00,
    SCMUX_MODE_SYNC  = 2'b01,
    SCMUX_MODE_SDLC  = 2'b10,
    SCMUX_MODE_EXT   = 2'b11
  } scmux_mode_t;

  typedef struct packed {
    logic        osc_en;
    scmux_src_t  rx_src;
    scmux_src_t  tx_src;
    logic        pin_out;
    scmux_pinsel_t pin_sel;
  } scmux_cmc_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } scmux_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scmux_apb_rsp_t;

  typedef struct packed {
    logic recv_xmit_clock_pin;
    logic xmit_recv_clock_pin;
    logic align_b;
    logic baud;
    logic loop_rx;
    logic loop_tx;
    logic osc;
  } scmux_clkin_t;

endpackage

// >>> scmux_sync3.sv
/*
  Three-flop input synchroniser with agreement of stages two and three.
  Assumes an asynchronous input and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module scmux_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } scmux_sy_t;

  scmux_sy_t st_q;
  scmux_sy_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.o[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{s1: RST, s2: RST, s3: RST, o: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.o;
endmodule

// >>> scmux_top.sv
/*
  Clock mux and frame-align pin logic for one serial channel, APB slave.
  Assumes clock sources arrive as asynchronous levels sampled by clk.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module scmux_top
  import scmux_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // APB
  input  wire scmux_pkg::scmux_apb_req_t  apb_req,
  output logic                            apb_prdata_valid,
  output scmux_pkg::scmux_apb_rsp_t       apb_rsp,
  // Clock sources and pins
  input  wire scmux_pkg::scmux_clkin_t    clk_in,
  // Xmit/recv clock pin drive
  output logic                            xmit_recv_clock_pin_o,
  output logic                            xmit_recv_clock_pin_oe,
  // Align pin drive and oscillator
  output logic                            align_oe,
  output logic                            osc_amp_en,
  // Selected clocks
  output logic                            rx_clk,
  output logic                            tx_clk,
  output logic                            rx_sample,
  // Receiver control
  output logic                            hunt,
  output logic                            rx_accept,
  output logic                            flag_force,
  output logic                            tx_monosync,
  output logic                            status_event,
  output logic                            sync_hunt_stat
);
  import scmux_pkg::*;

  typedef struct packed {
    scmux_cmc_t     cmc;
    logic [2:0]     mode;
    scmux_apb_rsp_t rsp;
    logic           rvalid;
    logic           xmit_recv_clock_pin_o;
    logic           xmit_recv_clock_pin_oe;
    logic           align_oe;
    logic           osc_amp;
    logic           rx_clk;
    logic           tx_clk;
    logic           rx_prev;
    logic           rx_sample;
    logic           align_prev;
    logic           hunt;
    logic           accept;
    logic           flag;
    logic           mono;
    logic           ev;
    logic           stat;
  } scmux_st_t;

  scmux_st_t    st_q;
  scmux_st_t    st_d;
  scmux_clkin_t cs;

  scmux_sync3 #(
    .W   (7),
    .RST (SCMUX_PIN_RST)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (clk_in),
    .q     (cs)
  );

  function automatic logic pick_src(input scmux_src_t s, input logic rt,
                                    input logic tr, input logic bd, input logic lp);
    logic r;
    r = rt;
    unique case (s)
      SCMUX_SRC_RECV_XMIT_CLOCK_PIN: r = rt;
      SCMUX_SRC_XMIT_RECV_CLOCK_PIN: r = tr;
      SCMUX_SRC_BAUD: r = bd;
      SCMUX_SRC_LOOP: r = lp;
    endcase
    return r;
  endfunction

  function automatic logic ext_sync_in(input logic [2:0] md, input scmux_mode_t want,
                                       input logic osc_on);
    return (md[1:0] == want) && md[2] && !osc_on;
  endfunction

  function automatic logic pin_drive(input scmux_pinsel_t sel, input logic osc_on,
                                     input logic osc, input logic txc, input logic bd,
                                     input logic lp);
    logic r;
    r = 1'b1;
    unique case (sel)
      SCMUX_PIN_OSC:  r = osc_on ? osc : 1'b1;
      SCMUX_PIN_TXC:  r = txc;
      SCMUX_PIN_BAUD: r = bd;
      SCMUX_PIN_LOOP: r = lp;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] status_word(input logic mono, input logic flag,
                                              input logic acc, input logic hnt,
                                              input logic stat);
    logic [31:0] w;
    w    = 32'h0000_0000;
    w[0] = stat;
    w[1] = hnt;
    w[2] = acc;
    w[3] = flag;
    w[4] = mono;
    return w;
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    logic r;
    r = 1'b0;
    unique case (a)
      SCMUX_ADDR_CMC, SCMUX_ADDR_MODE, SCMUX_ADDR_CMD, SCMUX_ADDR_STATUS: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic       wr_acc;
  logic       rd_acc;
  logic       recv_xmit_clock_pin_eff;
  logic       ext_ok;
  logic       pin_is_src;
  logic       align_lvl;
  logic [1:0] mode_f;

  always_comb begin
    st_d   = st_q;
    wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    mode_f = st_q.mode[1:0];

    // APB slave, zero wait states
    st_d.rsp.pready  = apb_req.psel && !apb_req.penable;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata  = 32'h0000_0000;
    st_d.rvalid      = 1'b0;
    st_d.ev          = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      st_d.rsp.pslverr = !reg_mapped(apb_req.paddr);
      unique case (apb_req.paddr)
        SCMUX_ADDR_CMC, SCMUX_ADDR_CMD: ;
        SCMUX_ADDR_MODE: st_d.rsp.prdata = {29'h0, st_q.mode};
        SCMUX_ADDR_STATUS: begin
          st_d.rsp.prdata = status_word(st_q.mono, st_q.flag, st_q.accept,
                                        st_q.hunt, st_q.stat);
          st_d.rvalid     = !apb_req.pwrite;
        end
        default: ;
      endcase
    end
    if (wr_acc && st_q.rsp.pready && reg_mapped(apb_req.paddr)) begin
      unique case (apb_req.paddr)
        SCMUX_ADDR_CMC:  st_d.cmc  = scmux_cmc_t'(apb_req.pwdata[7:0]);
        SCMUX_ADDR_MODE: st_d.mode = apb_req.pwdata[2:0];
        SCMUX_ADDR_CMD: begin
          if (apb_req.pwdata[SCMUX_CMD_HUNT]) begin
            st_d.hunt   = 1'b1;
            st_d.accept = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_acc) begin
      st_d.rsp.pready = 1'b0;
    end

    // Oscillator and pin roles
    st_d.osc_amp  = st_q.cmc.osc_en;
    st_d.align_oe = 1'b0;
    recv_xmit_clock_pin_eff      = st_q.cmc.osc_en ? cs.osc : cs.recv_xmit_clock_pin;
    ext_ok        = (mode_f == SCMUX_MODE_EXT) && !st_q.cmc.osc_en;

    // Clock selection
    st_d.rx_clk = pick_src(st_q.cmc.rx_src, recv_xmit_clock_pin_eff, cs.xmit_recv_clock_pin, cs.baud, cs.loop_tx);
    st_d.tx_clk = pick_src(st_q.cmc.tx_src, recv_xmit_clock_pin_eff, cs.xmit_recv_clock_pin, cs.baud, cs.loop_tx);

    // Receiver samples on the rising receive clock edge
    st_d.rx_prev   = st_d.rx_clk;
    st_d.rx_sample = st_d.rx_clk && !st_q.rx_prev;

    // Xmit/recv pin direction and content
    pin_is_src   = (st_q.cmc.rx_src == SCMUX_SRC_XMIT_RECV_CLOCK_PIN) || (st_q.cmc.tx_src == SCMUX_SRC_XMIT_RECV_CLOCK_PIN);
    st_d.xmit_recv_clock_pin_oe = st_q.cmc.pin_out && !pin_is_src;
    st_d.xmit_recv_clock_pin_o  = pin_drive(st_q.cmc.pin_sel, st_q.cmc.osc_en, cs.osc, st_d.tx_clk,
                             cs.baud, cs.loop_rx);

    // Sync/hunt status
    align_lvl = st_q.cmc.osc_en ? 1'b1 : cs.align_b;
    if (st_q.cmc.osc_en) begin
      st_d.stat = 1'b0;
    end else if (ext_ok) begin
      st_d.stat = cs.align_b;
    end else begin
      st_d.stat = st_q.hunt;
    end

    // Align pin edges
    st_d.align_prev = align_lvl;
    st_d.flag       = 1'b0;
    st_d.mono       = ext_sync_in(st_q.mode, SCMUX_MODE_SYNC, st_q.cmc.osc_en);
    if (align_lvl != st_q.align_prev && st_q.mode[SCMUX_IE_BIT]
        && !st_q.cmc.osc_en) begin
      st_d.ev = 1'b1;
    end
    if (!align_lvl && st_q.align_prev && st_q.hunt && st_q.rx_sample) begin
      // Falling edge leaves hunt at the next rising receive edge
      if (ext_ok || st_d.mono) begin
        st_d.hunt   = 1'b0;
        st_d.accept = 1'b1;
      end
    end else if (!align_lvl && st_q.hunt && st_q.rx_sample && (ext_ok || st_d.mono)) begin
      st_d.hunt   = 1'b0;
      st_d.accept = 1'b1;
    end
    if (ext_sync_in(st_q.mode, SCMUX_MODE_SDLC, st_q.cmc.osc_en)
        && align_lvl != st_q.align_prev) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q            <= '0;
      st_q.cmc        <= scmux_cmc_t'(SCMUX_CMC_RST);
      st_q.mode       <= SCMUX_MODE_RST;
      st_q.hunt       <= 1'b1;
      st_q.align_prev <= 1'b1;
      st_q.xmit_recv_clock_pin_o     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp          = st_q.rsp;
  assign apb_prdata_valid = st_q.rvalid;
  assign xmit_recv_clock_pin_o           = st_q.xmit_recv_clock_pin_o;
  assign xmit_recv_clock_pin_oe          = st_q.xmit_recv_clock_pin_oe;
  assign align_oe         = st_q.align_oe;
  assign osc_amp_en       = st_q.osc_amp;
  assign rx_clk           = st_q.rx_clk;
  assign tx_clk           = st_q.tx_clk;
  assign rx_sample        = st_q.rx_sample;
  assign hunt             = st_q.hunt;
  assign rx_accept        = st_q.accept;
  assign flag_force       = st_q.flag;
  assign tx_monosync      = st_q.mono;
  assign status_event     = st_q.ev;
  assign sync_hunt_stat   = st_q.stat;
endmodule

// >>> scmux_far.sv
/*
  Far-side clock sources and frame-align logic.
  Assumes a 100 ns bench clock samples these levels.
*/
`timescale 1ns/1ps
module scmux_far
  import scmux_pkg::*;
(
  // Align control from bench
  input  wire logic               align_lo,
  // Sources
  output scmux_pkg::scmux_clkin_t cin
);
  logic r = 1'b0;
  logic t = 1'b0;
  logic b = 1'b0;
  logic l = 1'b0;
  logic o = 1'b0;
  always #400 r = !r;
  always #800 t = !t;
  always #200 b = !b;
  always #1600 l = !l;
  // Oscillator modelled as already settled
  always #600 o = !o;
  // Align held low by external match logic
  assign cin = '{recv_xmit_clock_pin: r, xmit_recv_clock_pin: t, align_b: !align_lo, baud: b,
                 loop_rx: l, loop_tx: l, osc: o};
endmodule

// >>> scmux_top_properties.sv
/*
  Port checker for the clock mux block.
  Assumes it is bound into every instance of the top.
*/
`timescale 1ns/1ps
module scmux_chk
  import scmux_pkg::*;
(
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst_b,
  // Watched ports
  input wire scmux_pkg::scmux_apb_req_t apb_req,
  input wire scmux_pkg::scmux_apb_rsp_t apb_rsp,
  input wire logic                      align_oe,
  input wire logic                      osc_amp_en,
  input wire logic                      rx_clk,
  input wire logic                      rx_sample,
  input wire logic                      hunt,
  input wire logic                      rx_accept,
  input wire logic                      flag_force,
  input wire logic                      tx_monosync,
  input wire logic                      status_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  align_idle_a: assert property (!align_oe) else $error("align pin driven");
  osc_no_ext_a: assert property (osc_amp_en && $past(osc_amp_en) |->
    !tx_monosync && !flag_force) else $error("ext sync with oscillator on");
  ready_zero_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready late");
  ready_acc_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  sample_rise_a: assert property (rx_sample |-> rx_clk && !$past(rx_clk))
    else $error("sample without clock rise");
  hunt_edge_a: assert property ($fell(hunt) |-> $past(rx_sample))
    else $error("hunt left off a receive edge");
  sample_pulse_a: assert property (rx_sample |=> !rx_sample) else $error("sample held");
  hunt_exit_a: assert property ($fell(hunt) |-> ##[0:1] rx_accept)
    else $error("hunt left without accept");
  accept_hunt_a: assert property (rx_accept |-> !hunt) else $error("accept in hunt");
  event_pulse_a: assert property (status_event |=> !status_event)
    else $error("event held");
  flag_pulse_a: assert property (flag_force |=> !flag_force) else $error("flag held");
endmodule
bind scmux_top scmux_chk i_chk (.clk(clk), .rst_b(rst_b), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .align_oe(align_oe), .osc_amp_en(osc_amp_en), .rx_clk(rx_clk),
  .rx_sample(rx_sample), .hunt(hunt), .rx_accept(rx_accept), .flag_force(flag_force),
  .tx_monosync(tx_monosync), .status_event(status_event));

// >>> scmux_top_tb_top.sv
/*
  Self-checking bench for the clock mux block.
  Assumes the far-side model supplies all clock sources.
*/
`timescale 1ns/1ps
module scmux_top_tb_top;
  import scmux_pkg::*;
  logic           clk = 1'b0;
  logic           rst_b = 1'b0;
  logic           align_lo = 1'b0;
  scmux_apb_req_t req = '0;
  scmux_apb_rsp_t rsp;
  scmux_clkin_t   cin;
  logic           rx_clk, tx_clk, xmit_recv_clock_pin_o, xmit_recv_clock_pin_oe, osc_amp_en, hunt, rx_accept;
  logic           flag_force, tx_monosync, status_event, sync_hunt_stat, err, pvld, rdv;
  logic [31:0]    rd;
  int             n_fail = 0;
  int             tests_run = 0;
  int             cyc = 0;
  int             nev = 0;
  int             nfl = 0;
  int             nr, nt, no, s, e0;
  int             esrc[4] = '{12, 6, 24, 3};
  int             epin[4] = '{0, 24, 24, 3};
  always #50 clk = !clk;
  scmux_far i_far (.align_lo(align_lo), .cin(cin));
  scmux_top i_dut (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_prdata_valid(pvld),
    .apb_rsp(rsp), .clk_in(cin), .xmit_recv_clock_pin_o(xmit_recv_clock_pin_o), .xmit_recv_clock_pin_oe(xmit_recv_clock_pin_oe), .align_oe(),
    .osc_amp_en(osc_amp_en), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_sample(),
    .hunt(hunt), .rx_accept(rx_accept), .flag_force(flag_force),
    .tx_monosync(tx_monosync), .status_event(status_event),
    .sync_hunt_stat(sync_hunt_stat));
  always @(posedge clk) begin
    nev <= nev + status_event;
    nfl <= nfl + flag_force;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    rdv = pvld;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic edges();
    logic pr, pt, po;
    nr = 0;
    nt = 0;
    no = 0;
    repeat (8) @(posedge clk);
    {pr, pt, po} = {rx_clk, tx_clk, xmit_recv_clock_pin_o};
    repeat (96) begin
      @(posedge clk);
      nr += int'(rx_clk && !pr);
      nt += int'(tx_clk && !pt);
      no += int'(xmit_recv_clock_pin_o && !po);
      {pr, pt, po} = {rx_clk, tx_clk, xmit_recv_clock_pin_o};
    end
  endtask
  function automatic logic near(int n, int e);
    return n >= e - 1 && n <= e + 1;
  endfunction
  task automatic t_regs();
    apb(1'b0, SCMUX_ADDR_STATUS, '0);
    check("hunt_rst", rd, 32'h0000_0003);
    check("rd_valid", rdv, 1'b1);
    apb(1'b1, SCMUX_ADDR_CMC, 32'h0000_00FF);
    apb(1'b0, SCMUX_ADDR_CMC, '0);
    check("cmc_rd", rd, '0);
    check("cmc_valid", rdv, 1'b0);
    apb(1'b1, SCMUX_ADDR_MODE, 32'hFFFF_FFF5);
    apb(1'b0, SCMUX_ADDR_MODE, '0);
    check("mode_rd", rd, 32'h0000_0005);
    check("mapped_ok", err, 1'b0);
    apb(1'b1, SCMUX_ADDR_MODE, '0);
    apb(1'b0, 12'h010, '0);
    check("unmapped", err, 1'b1);
  endtask
  task automatic t_src();
    for (s = 0; s < 4; s++) begin
      apb(1'b1, SCMUX_ADDR_CMC, (s << 5) | (s << 3));
      edges();
      check("rx_clk", near(nr, esrc[s]), 1'b1);
      check("tx_clk", near(nt, esrc[s]), 1'b1);
    end
  endtask
  task automatic t_pin();
    for (s = 0; s < 4; s++) begin
      apb(1'b1, SCMUX_ADDR_CMC, 32'h54 | s);
      edges();
      check("pin_oe", xmit_recv_clock_pin_oe, 1'b1);
      check("pin_out", near(no, epin[s]), 1'b1);
      if (s == 0) check("pin_high", xmit_recv_clock_pin_o, 1'b1);
    end
    apb(1'b1, SCMUX_ADDR_CMC, 32'h4C);
    edges();
    check("pin_src", xmit_recv_clock_pin_oe, 1'b0);
    apb(1'b1, SCMUX_ADDR_CMC, 32'h50);
    edges();
    check("pin_off", xmit_recv_clock_pin_oe, 1'b0);
  endtask
  task automatic t_osc();
    apb(1'b1, SCMUX_ADDR_CMC, 32'h84);
    apb(1'b1, SCMUX_ADDR_MODE, 32'h0);
    align_lo <= 1'b1;
    edges();
    check("amp_on", osc_amp_en, 1'b1);
    check("rx_osc", near(nr, 8), 1'b1);
    check("pin_osc", near(no, 8), 1'b1);
    check("stat_zero", sync_hunt_stat, 1'b0);
    align_lo <= 1'b0;
    apb(1'b1, SCMUX_ADDR_MODE, 32'h5);
    check("mono_osc", tx_monosync, 1'b0);
    apb(1'b1, SCMUX_ADDR_CMC, 32'h0);
    repeat (4) @(posedge clk);
    check("amp_off", osc_amp_en, 1'b0);
    check("mono", tx_monosync, 1'b1);
  endtask
  task automatic t_ext(logic [2:0] m, int ev);
    logic s1;
    apb(1'b1, SCMUX_ADDR_MODE, m);
    apb(1'b1, SCMUX_ADDR_CMD, 32'h1);
    s1 = sync_hunt_stat;
    e0 = nev;
    align_lo <= 1'b1;
    repeat (24) @(posedge clk);
    check("stat_mirror", sync_hunt_stat, !s1);
    check("hunt_exit", hunt, 1'b0);
    check("accept", rx_accept, 1'b1);
    align_lo <= 1'b0;
    repeat (24) @(posedge clk);
    check("events", nev - e0, ev);
    apb(1'b1, SCMUX_ADDR_CMD, 32'h1);
    check("hunt_cmd", {hunt, rx_accept}, 2'b10);
  endtask
  task automatic t_sdlc();
    apb(1'b1, SCMUX_ADDR_MODE, 32'h6);
    apb(1'b1, SCMUX_ADDR_CMD, 32'h1);
    e0 = nfl;
    align_lo <= 1'b1;
    repeat (24) @(posedge clk);
    check("flag", nfl != e0, 1'b1);
    align_lo <= 1'b0;
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_src();
    t_pin();
    t_osc();
    t_ext(3'h7, 2);
    t_ext(3'h3, 0);
    t_sdlc();
    summarize();
  end
endmodule
